// ==== hdl/pie_map.vh ====
// Purpose: constants for the processor interrupt entry block
// Assumes: included by bare name from design files
// Notes:   register offsets are byte addresses on the avalon slave
`ifndef PIE_MAP_VH
`define PIE_MAP_VH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define PIE_OFF_CTRL      6'h00
`define PIE_OFF_STATUS    6'h04
`define PIE_OFF_SEQ       6'h08
`define PIE_OFF_EXTVEC    6'h0c
`define PIE_OFF_INTVEC    6'h10
`define PIE_OFF_SAVED     6'h14
`define PIE_OFF_IND       6'h18
`define PIE_OFF_SAVEIMG   6'h1c
`define PIE_OFF_CAUSE     6'h20
// ****************************************************************
// indicator field layout (8 bits)
// ****************************************************************
`define PIE_IND_ARITH_LO  0
`define PIE_IND_ARITH_HI  1
`define PIE_IND_CMP_LO    2
`define PIE_IND_CMP_HI    3
`define PIE_IND_AMODE_LO  4
`define PIE_IND_AMODE_HI  5
`define PIE_IND_TRAP      6
`define PIE_AMODE_THREE   2'h1
`define PIE_AMODE_MAX     2'h3
// ****************************************************************
// source / status bit positions
// ****************************************************************
`define PIE_SRC_CONSOLE   0
`define PIE_SRC_SVC       1
`define PIE_SRC_PERIPH    2
`define PIE_ST_EXT_TYPE   3
`define PIE_ST_INT_TYPE   4
`define PIE_ST_EXT_MODE   5
`define PIE_ST_INT_MODE   6
// ****************************************************************
// control register bits
// ****************************************************************
`define PIE_CTL_RUN       0
`define PIE_CTL_CLR_SRC   1
`define PIE_CTL_CLR_CAUSE 2
`endif

// ==== hdl/pie_entry.v ====
// Purpose: interrupt entry, priority and return sequencing for the processor
// Assumes: one clock, async active-high reset acting as initialization
// Notes:   avalon-mm slave for software view; instruction events are strobes
//
// Contract
// RQ1: take console, supervisor call, peripheral requests
// RQ2: external request records source and external type
// RQ3: external needs run, no ext mode, fetch, cycle
// RQ4: busy transfer rewinds sequence to op-code address
// RQ5: save indicators, then clear arithmetic indicators
// RQ6: enter three-character non-trap addressing
// RQ7: swap sequence and external vector registers
// RQ8: set external mode, blocking further interrupts
// RQ9: peripheral holds request until serviced or off
// RQ10: protection violation records cause, internal type
// RQ11: internal needs same conditions, no internal mode
// RQ12: priority follows standard, internal, external mode
// RQ13: external requests stay pending during external mode
// RQ14: internal entry swaps sequence and internal vector
// RQ15: then set internal interrupt mode
// RQ16: internal entry does not save indicators
// RQ17: save-state stores context and source indicators
// RQ18: restore-state reloads saved indicators and variant
// RQ19: resume returns, honoring altered sector bits
// RQ20: supervisor call causes external interruption
// RQ21: restore variant zero gives max address mode
// RQ22: peripheral forwards only with interrupt and allow
// RQ23: resume clears active interrupt mode
// RQ24: initialization clears both interrupt modes
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
`include "pie_map.vh"
`default_nettype none
module pie_entry #(
    parameter AW = 16,                        // sequence register width
    parameter CW = 4                          // internal cause width
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          console_btn,         // asynchronous console button
    input  wire          periph_req,          // asynchronous peripheral line
    input  wire          svc_exec,            // supervisor call executed
    input  wire          prot_viol,           // storage protection violation
    input  wire [CW-1:0] prot_cause,          // violation cause code
    input  wire          opcode_fetch,        // op code about to be extracted
    input  wire          cycle_granted,       // memory cycle given to processor
    input  wire          busy_xfer,           // transfer hit a busy channel
    input  wire [AW-1:0] xfer_op_addr,        // op-code address of that transfer
    input  wire          next_seq_valid,      // normal sequencing advance
    input  wire [AW-1:0] next_seq,            // advanced sequence value
    input  wire          save_exec,           // save-state instruction
    input  wire          restore_exec,        // restore-state instruction
    input  wire          restore_v2,          // variant bit of restore
    input  wire [7:0]    restore_ind,         // indicators read back from memory
    input  wire          resume_exec,         // resume instruction
    input  wire [AW-1:0] resume_seq,          // resume target incl. sector bits
    input  wire [5:0]    avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    output reg  [31:0]   avs_readdata,
    output wire          avs_waitrequest,
    output reg  [AW-1:0] seq_out_q,           // sequence register
    output reg  [7:0]    ind_out_q,           // live indicators
    output reg           ext_mode_q,          // external interrupt mode
    output reg           int_mode_q,          // internal interrupt mode
    output reg           take_ext_q,          // one-cycle entry pulse
    output reg           take_int_q,          // one-cycle entry pulse
    output reg  [15:0]   save_image_q         // image written by save-state
);
    // ****************************************************************
    // state
    // ****************************************************************
    reg [AW-1:0] ext_vec_q;                   // external vector register
    reg [AW-1:0] int_vec_q;                   // internal vector register
    reg [7:0]    saved_ind_q;                 // saved indicator register
    reg [2:0]    src_q;                       // external sources; console and svc sticky, peripheral mirrors line
    reg          ext_type_q;                  // external type flag
    reg          int_type_q;                  // internal type flag
    reg          int_pend_q;                  // internal request pending
    reg [CW-1:0] cause_q;                     // internal cause
    reg          run_q;                       // run mode, software set
    reg          ack_q;                       // bus answer phase
    reg          con_s1_q, con_s2_q, con_s3_q;
    reg          per_s1_q, per_s2_q;

    // ****************************************************************
    // pin synchronisers; console edge taken after second stage
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            con_s1_q <= 1'b0;
            con_s2_q <= 1'b0;
            con_s3_q <= 1'b0;
            per_s1_q <= 1'b0;
            per_s2_q <= 1'b0;
        end else begin
            con_s1_q <= console_btn;
            con_s2_q <= con_s1_q;
            con_s3_q <= con_s2_q;
            per_s1_q <= periph_req;
            per_s2_q <= per_s1_q;
        end
    end

    wire con_rise = con_s2_q & ~con_s3_q;    // button press, one pulse
    // peripheral is level: it stays until serviced, so no latch needed
    wire ext_any  = src_q[`PIE_SRC_CONSOLE] | src_q[`PIE_SRC_SVC] | per_s2_q; // RQ9 RQ22 RQ13
    wire accept_ok = run_q & opcode_fetch & cycle_granted;               // RQ3
    wire do_ext   = accept_ok & ~ext_mode_q & ext_any;                   // RQ3 RQ12
    // external outranks internal when both are eligible
    wire do_int   = accept_ok & ~ext_mode_q & ~int_mode_q & int_pend_q & ~do_ext; // RQ11 RQ12

    // ****************************************************************
    // bus decode: one wait cycle then answer
    // ****************************************************************
    wire bus_req  = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_q;
    wire wr_go    = avs_write & ack_q;
    wire ctl_wr   = wr_go & (avs_address == `PIE_OFF_CTRL);
    wire clr_src  = ctl_wr & avs_writedata[`PIE_CTL_CLR_SRC];
    wire clr_cause = ctl_wr & avs_writedata[`PIE_CTL_CLR_CAUSE];

    // ****************************************************************
    // source and type indicators; a set wins over a software clear
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            src_q      <= 3'h0;
            ext_type_q <= 1'b0;
            int_type_q <= 1'b0;
            int_pend_q <= 1'b0;
            cause_q    <= {CW{1'b0}};
        end else begin
            // console and supervisor call latch; peripheral mirrors its line
            src_q[`PIE_SRC_CONSOLE] <= con_rise | (src_q[`PIE_SRC_CONSOLE] & ~clr_src); // RQ1 RQ2
            src_q[`PIE_SRC_SVC]     <= svc_exec | (src_q[`PIE_SRC_SVC] & ~clr_src);     // RQ20 RQ2
            src_q[`PIE_SRC_PERIPH]  <= per_s2_q;                                          // RQ1
            ext_type_q <= con_rise | svc_exec | per_s2_q | (ext_type_q & ~clr_src);      // RQ2
            int_type_q <= prot_viol | (int_type_q & ~clr_cause);                         // RQ10
            if (prot_viol)
                cause_q <= prot_cause;                                                    // RQ10
            else if (clr_cause)
                cause_q <= {CW{1'b0}};
            // pending internal request ends when taken
            int_pend_q <= prot_viol | (int_pend_q & ~do_int);
        end
    end

    // ****************************************************************
    // sequencing, vectors, modes and indicators
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_out_q    <= {AW{1'b0}};
            ext_vec_q    <= {AW{1'b0}};
            int_vec_q    <= {AW{1'b0}};
            ind_out_q    <= 8'h00;
            saved_ind_q  <= 8'h00;
            ext_mode_q   <= 1'b0;                                                 // RQ24
            int_mode_q   <= 1'b0;                                                 // RQ24
            take_ext_q   <= 1'b0;
            take_int_q   <= 1'b0;
            save_image_q <= 16'h0000;
            run_q        <= 1'b0;
        end else begin
            take_ext_q <= do_ext;
            take_int_q <= do_int;
            if (ctl_wr)
                run_q <= avs_writedata[`PIE_CTL_RUN];
            if (do_ext) begin
                saved_ind_q <= ind_out_q;                                         // RQ5
                ind_out_q[`PIE_IND_ARITH_HI:`PIE_IND_ARITH_LO] <= 2'h0;          // RQ5
                ind_out_q[`PIE_IND_AMODE_HI:`PIE_IND_AMODE_LO] <= `PIE_AMODE_THREE; // RQ6
                ind_out_q[`PIE_IND_TRAP] <= 1'b0;                                 // RQ6
                seq_out_q  <= ext_vec_q;                                          // RQ7
                ext_vec_q  <= seq_out_q;                                          // RQ7
                ext_mode_q <= 1'b1;                                               // RQ8
            end else if (do_int) begin
                // indicators untouched; the handler saves them itself
                seq_out_q  <= int_vec_q;                                          // RQ14 RQ16
                int_vec_q  <= seq_out_q;                                          // RQ14
                int_mode_q <= 1'b1;                                               // RQ15
            end else if (resume_exec) begin
                seq_out_q  <= resume_seq;                                         // RQ19
                ext_mode_q <= 1'b0;                                               // RQ23
                int_mode_q <= 1'b0;                                               // RQ23
            end else if (busy_xfer) begin
                seq_out_q <= xfer_op_addr;                                        // RQ4
            end else if (next_seq_valid) begin
                seq_out_q <= next_seq;
            end else if (wr_go && avs_address == `PIE_OFF_SEQ) begin
                seq_out_q <= avs_writedata[AW-1:0];
            end
            if (!do_ext && wr_go && avs_address == `PIE_OFF_EXTVEC)
                ext_vec_q <= avs_writedata[AW-1:0];
            if (!do_int && wr_go && avs_address == `PIE_OFF_INTVEC)
                int_vec_q <= avs_writedata[AW-1:0];
            if (!do_ext && restore_exec) begin
                ind_out_q <= restore_ind;                                         // RQ18
                if (!restore_v2)
                    ind_out_q[`PIE_IND_AMODE_HI:`PIE_IND_AMODE_LO] <= `PIE_AMODE_MAX; // RQ21
            end
            if (save_exec)
                save_image_q <= {1'b0, int_type_q, ext_type_q, src_q,
                                 saved_ind_q[1:0], ind_out_q};                    // RQ17
        end
    end

    // ****************************************************************
    // bus answer and read mux
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    `PIE_OFF_CTRL:    avs_readdata <= {31'h0, run_q};
                    `PIE_OFF_STATUS:  avs_readdata <= {25'h0, int_mode_q, ext_mode_q,
                                                       int_type_q, ext_type_q, src_q};
                    `PIE_OFF_SEQ:     avs_readdata <= {{(32-AW){1'b0}}, seq_out_q};
                    `PIE_OFF_EXTVEC:  avs_readdata <= {{(32-AW){1'b0}}, ext_vec_q};
                    `PIE_OFF_INTVEC:  avs_readdata <= {{(32-AW){1'b0}}, int_vec_q};
                    `PIE_OFF_SAVED:   avs_readdata <= {24'h0, saved_ind_q};
                    `PIE_OFF_IND:     avs_readdata <= {24'h0, ind_out_q};
                    `PIE_OFF_SAVEIMG: avs_readdata <= {16'h0, save_image_q};
                    `PIE_OFF_CAUSE:   avs_readdata <= {{(32-CW){1'b0}}, cause_q};
                    default:          avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/pie_far_model.sv ====
// Purpose: far side model: operator console button and one peripheral control
// Assumes: bench changes the strobes right after a rising clock edge
// Notes:   request leaves only when interrupt function and allow are both on
`timescale 1ns/1ns
`default_nettype none
module pie_far_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic press,        // operator holds the console button
    input  wire logic allow,        // program-controlled allow function
    input  wire logic done,         // control became not busy
    input  wire logic stop,         // interrupt function switched off
    input  wire logic peripheral_transfer_instruction,          // transfer instruction received
    output var  logic console_btn,
    output var  logic periph_req
);
    logic intr_q;                   // interrupt function of the control
    // request is repeated until a transfer, a switch-off or initialization
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            intr_q <= 1'b0;
        end else if (stop || peripheral_transfer_instruction) begin
            intr_q <= 1'b0;
        end else if (done) begin
            intr_q <= 1'b1;
        end
    end
    // button acts straight on the processor
    always_comb console_btn = press;
    // keeps asking through external mode; never forwarded without allow
    always_comb periph_req = intr_q && allow && !reset;
endmodule
`default_nettype wire

// ==== tb/pie_entry_props.sv ====
// Purpose: port-level checks on the interrupt entry block
// Assumes: take pulses rise at the entry edge, one cycle after the fetch point
// Notes:   checks skip cycles where the bench overlaps a fetch point
`timescale 1ns/1ns
`default_nettype none
module pie_entry_props #(
    parameter AW = 16
) (
    input wire logic          clk,
    input wire logic          reset,
    input wire logic          opcode_fetch,
    input wire logic          cycle_granted,
    input wire logic          busy_xfer,
    input wire logic [AW-1:0] xfer_op_addr,
    input wire logic          restore_exec,
    input wire logic          restore_v2,
    input wire logic          resume_exec,
    input wire logic [AW-1:0] resume_seq,
    input wire logic [AW-1:0] seq_out_q,
    input wire logic [7:0]    ind_out_q,
    input wire logic          ext_mode_q,
    input wire logic          int_mode_q,
    input wire logic          take_ext_q,
    input wire logic          take_int_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_entry_cond: assert property (
        (take_ext_q || take_int_q) |-> $past(opcode_fetch && cycle_granted))
        else $error("entry taken off a fetch point");
    a_ext_blocked: assert property (
        take_ext_q |-> !$past(ext_mode_q) && ext_mode_q)
        else $error("external entry while blocked or mode not set");
    a_int_blocked: assert property (
        take_int_q |-> !$past(ext_mode_q) && !$past(int_mode_q) && int_mode_q)
        else $error("internal entry while blocked or mode not set");
    a_ext_ind_clear: assert property (
        take_ext_q |-> ind_out_q[1:0] == 2'h0 && ind_out_q[5:4] == 2'h1 && !ind_out_q[6])
        else $error("external entry indicators wrong");
    a_int_ind_kept: assert property (
        take_int_q |-> ind_out_q == $past(ind_out_q))
        else $error("internal entry touched indicators");
    a_busy_rewind: assert property (
        busy_xfer && !resume_exec && !opcode_fetch |=> seq_out_q == $past(xfer_op_addr))
        else $error("busy transfer did not rewind sequence");
    a_resume_clear: assert property (
        resume_exec && !opcode_fetch |=> !ext_mode_q && !int_mode_q
            && seq_out_q == $past(resume_seq))
        else $error("resume left a mode or wrong sequence");
    a_restore_max: assert property (
        restore_exec && !restore_v2 && !opcode_fetch |=> ind_out_q[5:4] == 2'h3)
        else $error("restore variant zero not in max mode");
    a_init_clear: assert property (
        $fell(reset) |-> !ext_mode_q && !int_mode_q)
        else $error("modes not cleared by initialization");
    c_nested: cover property (take_ext_q && int_mode_q);
    c_internal: cover property (take_int_q);
    c_rewind: cover property (busy_xfer && !opcode_fetch);
endmodule
bind pie_entry pie_entry_props #(.AW(AW)) i_props (
    .clk(clk), .reset(reset), .opcode_fetch(opcode_fetch), .cycle_granted(cycle_granted),
    .busy_xfer(busy_xfer), .xfer_op_addr(xfer_op_addr), .restore_exec(restore_exec),
    .restore_v2(restore_v2), .resume_exec(resume_exec), .resume_seq(resume_seq),
    .seq_out_q(seq_out_q), .ind_out_q(ind_out_q), .ext_mode_q(ext_mode_q),
    .int_mode_q(int_mode_q), .take_ext_q(take_ext_q), .take_int_q(take_int_q));
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the interrupt entry block
// Assumes: bus answers after one wait state; take pulses one cycle late
// Notes:   vector and sequence values are arbitrary patterns
`timescale 1ns/1ns
`default_nettype none
`include "pie_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic        clk, reset, press, allow, done, stop, peripheral_transfer_instruction, console_btn, periph_req;
    logic        svc_exec, prot_viol, opcode_fetch, cycle_granted, busy_xfer;
    logic        save_exec, restore_exec, restore_v2, resume_exec, avs_read, avs_write;
    logic        avs_waitrequest, ext_mode_q, int_mode_q, take_ext_q, take_int_q;
    logic [3:0]  prot_cause;
    logic [7:0]  restore_ind, ind_out_q;
    logic [5:0]  avs_address;
    logic [15:0] xfer_op_addr, resume_seq, seq_out_q, save_image_q;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          bad_count, check_count, cyc;
    pie_far_model i_far (.clk(clk), .reset(reset), .press(press), .allow(allow),
        .done(done), .stop(stop), .peripheral_transfer_instruction(peripheral_transfer_instruction), .console_btn(console_btn), .periph_req(periph_req));
    pie_entry #(.AW(16), .CW(4)) i_dut (.clk(clk), .reset(reset), .console_btn(console_btn),
        .periph_req(periph_req), .svc_exec(svc_exec), .prot_viol(prot_viol),
        .prot_cause(prot_cause), .opcode_fetch(opcode_fetch), .cycle_granted(cycle_granted),
        .busy_xfer(busy_xfer), .xfer_op_addr(xfer_op_addr), .next_seq_valid(1'b0),
        .next_seq(16'h0000), .save_exec(save_exec), .restore_exec(restore_exec),
        .restore_v2(restore_v2), .restore_ind(restore_ind), .resume_exec(resume_exec),
        .resume_seq(resume_seq), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .seq_out_q(seq_out_q), .ind_out_q(ind_out_q),
        .ext_mode_q(ext_mode_q), .int_mode_q(int_mode_q), .take_ext_q(take_ext_q),
        .take_int_q(take_int_q), .save_image_q(save_image_q));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // verdict and end of run, also reached by the hang guard
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one avalon access; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and read data are seen as they stood at the edge;
        // only the hang guard ends a stalled access
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // bounded wait for an entry pulse
    task automatic wait_take(input logic ext);
        int n;
        n = 0;
        do @(negedge clk); while ((ext ? take_ext_q : take_int_q) !== 1'b1 && ++n < 40);
        `CHK(n < 40, 1'b1)
    endtask
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        {press, allow, done, stop, peripheral_transfer_instruction, svc_exec, prot_viol, opcode_fetch} = 8'h00;
        {cycle_granted, busy_xfer, save_exec, restore_exec, restore_v2, resume_exec} = 6'h00;
        {avs_read, avs_write, prot_cause, restore_ind, avs_address, avs_writedata} = 0;
        {xfer_op_addr, resume_seq} = 32'h0;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK({ext_mode_q, int_mode_q}, 2'b00)
        rd_chk(`PIE_OFF_STATUS, 32'h0);
        bus(1'b1, `PIE_OFF_EXTVEC, 32'h1234);
        bus(1'b1, `PIE_OFF_INTVEC, 32'h0456);
        bus(1'b1, `PIE_OFF_SEQ, 32'h0100);
        // indicators are not bus-writable: preload them through a restore
        @(posedge clk);
        {restore_exec, restore_v2, restore_ind} <= {2'b11, 8'h4b};
        @(posedge clk);
        restore_exec <= 1'b0;
        @(posedge clk);
        press <= 1'b1;
        opcode_fetch <= 1'b1;
        allow <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK(ext_mode_q, 1'b0)
        bus(1'b1, `PIE_OFF_CTRL, 32'h1);
        repeat (8) @(negedge clk);
        `CHK(ext_mode_q, 1'b0)
        @(posedge clk);
        cycle_granted <= 1'b1;
        wait_take(1'b1);
        `CHK({seq_out_q, ind_out_q}, {16'h1234, 8'h18})
        @(posedge clk);
        {press, prot_viol, done, prot_cause} <= {3'b011, 4'h3};
        @(posedge clk);
        {prot_viol, done} <= 2'b00;
        repeat (20) @(negedge clk);
        `CHK({int_mode_q, seq_out_q}, {1'b0, 16'h1234})
        rd_chk(`PIE_OFF_SAVED, 32'h4b);
        rd_chk(`PIE_OFF_EXTVEC, 32'h0100);
        rd_chk(`PIE_OFF_STATUS, 32'h3d);
        rd_chk(`PIE_OFF_CAUSE, 32'h3);
        @(posedge clk);
        {opcode_fetch, resume_exec, resume_seq} <= {2'b01, 16'h2100};
        @(posedge clk);
        {resume_exec, stop} <= 2'b01;
        @(negedge clk);
        `CHK({ext_mode_q, int_mode_q, seq_out_q}, {2'b00, 16'h2100})
        bus(1'b1, `PIE_OFF_CTRL, 32'h3);
        {stop, opcode_fetch} <= 2'b01;
        wait_take(1'b0);
        `CHK({int_mode_q, seq_out_q, ind_out_q}, {1'b1, 16'h0456, 8'h18})
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        wait_take(1'b1);
        `CHK({ext_mode_q, int_mode_q, seq_out_q}, {2'b11, 16'h0100})
        @(posedge clk);
        {opcode_fetch, peripheral_transfer_instruction, busy_xfer, xfer_op_addr} <= {3'b011, 16'h0777};
        @(posedge clk);
        {peripheral_transfer_instruction, busy_xfer} <= 2'b00;
        @(negedge clk);
        `CHK(seq_out_q, 16'h0777)
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {restore_exec, restore_v2, restore_ind} <= {1'b1, i[0], 8'h05};
            @(posedge clk);
            restore_exec <= 1'b0;
            @(negedge clk);
            `CHK(ind_out_q, i ? 8'h05 : 8'h35)
        end
        @(posedge clk);
        save_exec <= 1'b1;
        @(posedge clk);
        {save_exec, resume_exec} <= 2'b01;
        @(negedge clk);
        `CHK({save_image_q[13], save_image_q[7:0]}, {1'b1, 8'h05})
        @(posedge clk);
        resume_exec <= 1'b0;
        bus(1'b1, `PIE_OFF_CTRL, 32'h7);
        {opcode_fetch, svc_exec} <= 2'b11;
        @(posedge clk);
        svc_exec <= 1'b0;
        wait_take(1'b1);
        `CHK(seq_out_q, 16'h0456)
        bus(1'b0, `PIE_OFF_STATUS, 32'h0);
        `CHK(rd[1], 1'b1)
        rd_chk(`PIE_OFF_CAUSE, 32'h0);
        rd_chk(6'h3c, 32'h0);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK({ext_mode_q, int_mode_q}, 2'b00)
        wrap_up();
    end
endmodule
`default_nettype wire
